/* hw/plb_crc.sv */
// Byte-wise reflected CRC-32 register
module plb_crc (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic init,
	input wire logic upd,
	input wire logic [7:0] din,
	output logic [31:0] crc_q
);
	import plb_pkg::*;
	logic [31:0] crc_d;

	always_comb begin
		crc_d = crc_q ^ {24'h000000, din};
		for (int i = 0; i < 8; i++) begin
			crc_d = crc_d[0] ? ((crc_d >> 1) ^ CRC_POLY) : (crc_d >> 1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_q <= CRC_INIT;
		end else if (init) begin
			crc_q <= CRC_INIT;
		end else if (upd) begin
			crc_q <= crc_d;
		end
	end
endmodule // plb_crc

/* hw/plb_pkg.sv */
// Constants, register map and state codes of the boot loader
package plb_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int RST_DLY_US = 15;
	localparam int RST_DLY_CYC = RST_DLY_US * CLK_MHZ;
	localparam int QSPI_HALF = 4;
	localparam logic [7:0] QSPI_CMD = 8'h6B;
	localparam logic [5:0] QSPI_HDR_BITS = 6'h20;
	localparam logic [5:0] QSPI_DATA_AT = 6'h28;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] A_PLL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_SEC = 8'h08;
	localparam logic [7:0] A_CRC = 8'h0C;
	localparam logic [7:0] A_LEN = 8'h10;
	// PLL register fields
	localparam int PF_F = 0;
	localparam int PF_R = 12;
	localparam int PF_OUT_DIV = 20;
	// ==========================================================
	// PLL boot values and limits
	localparam logic [2:0] OUT_DIV_BOOT = 3'h1;
	localparam logic [5:0] R_BOOT = 6'h00;
	localparam logic [11:0] F_R40 = 12'h09F;
	localparam logic [11:0] F_R16 = 12'h03F;
	localparam logic [11:0] F_R8 = 12'h01F;
	localparam logic [11:0] F_R4 = 12'h00F;
	localparam int OSC_KHZ = 25000;
	localparam int VCO_MIN_KHZ = 260000;
	localparam int VCO_MAX_KHZ = 1300000;
	// ==========================================================
	// Boot image and memories
	localparam logic [10:0] OTP_SEC_ROW = 11'h7FF;
	localparam int SEC_BOOT_BIT = 5;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
	localparam int RAM_AW = 15;
	localparam logic [31:0] RAM_WORDS = 32'h00008000;

	typedef enum logic [8:0] {
		S_HOLD = 9'h001,
		S_DLY = 9'h002,
		S_SEC = 9'h004,
		S_SEL = 9'h008,
		S_LEN = 9'h010,
		S_PROG = 9'h020,
		S_CHK = 9'h040,
		S_RUN = 9'h080,
		S_ERR = 9'h100
	} plb_state_t;
endpackage

/* hw/plb_qspi.sv */
// Quad-output flash reader streaming bytes from address zero
module plb_qspi (
	input wire logic clk,
	input wire logic rst_n,
	plb_qspi_if.rd bs,
	input wire logic [3:0] di,
	output logic cs_n,
	output logic sck,
	output logic [3:0] dout,
	output logic [3:0] oe
);
	import plb_pkg::*;
	logic [3:0] di_m_q;
	logic [3:0] di_s_q;
	logic [2:0] div_q;
	logic [5:0] cnt_q;
	logic [31:0] sh_q;
	logic [3:0] nib_q;
	logic hi_q;
	logic vld_q;
	logic [7:0] dat_q;
	wire tick = (div_q == 3'(QSPI_HALF - 1));
	wire fall = tick & sck;

	assign bs.vld = vld_q;
	assign bs.dat = dat_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			di_m_q <= 4'h0;
			di_s_q <= 4'h0;
		end else begin
			di_m_q <= di;
			di_s_q <= di_m_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_n <= 1'b1;
			sck <= 1'b0;
			div_q <= 3'h0;
			cnt_q <= 6'h00;
			sh_q <= 32'h00000000;
			dout <= 4'h0;
			oe <= 4'h0;
			nib_q <= 4'h0;
			hi_q <= 1'b0;
			vld_q <= 1'b0;
			dat_q <= 8'h00;
		end else if (!bs.en) begin
			cs_n <= 1'b1;
			sck <= 1'b0;
			div_q <= 3'h0;
			cnt_q <= 6'h00;
			sh_q <= {QSPI_CMD, 24'h000000};
			oe <= 4'h0;
			hi_q <= 1'b0;
			vld_q <= 1'b0;
		end else if (cs_n) begin
			// Hold and write-protect lines stay high in the serial phase
			cs_n <= 1'b0;
			dout <= {3'b110, sh_q[31]};
			oe <= 4'b1101;
		end else begin
			vld_q <= 1'b0;
			div_q <= tick ? 3'h0 : div_q + 3'h1;
			if (tick) begin
				sck <= ~sck;
			end
			if (fall) begin
				cnt_q <= (cnt_q == QSPI_DATA_AT) ? cnt_q : cnt_q + 6'h01;
				sh_q <= {sh_q[30:0], 1'b0};
				dout <= {3'b110, sh_q[30]};
				if (cnt_q == QSPI_HDR_BITS - 6'h01) begin
					oe <= 4'h0;
				end
				if (cnt_q == QSPI_DATA_AT) begin
					hi_q <= ~hi_q;
					nib_q <= di_s_q;
					if (hi_q) begin
						dat_q <= {nib_q, di_s_q};
						vld_q <= 1'b1;
					end
				end
			end
		end
	end
endmodule // plb_qspi

/* hw/plb_qspi_if.sv */
// Byte stream between the loader and the flash reader
interface plb_qspi_if;
	logic en;
	logic vld;
	logic [7:0] dat;
	modport ctl(output en, input vld, input dat);
	modport rd(input en, output vld, output dat);
endinterface

/* hw/plb_top.sv */
// Strap, reset sequencing and boot loader with AHB-Lite registers

// Behaviour
// - Straps select PLL ratio 40/16/8/4
// - Boot output divider 1, R 0, table F
// - Tile clock from F, R, output divider
// - PLL register rewritable at run time
// - Reset pin low holds reset, pull-downs
// - Internal delay 15-150 us before boot
// - Tile 0 boots from embedded flash
// - Security bit 5 selects OTP boot
// - Image is length, program, check word
// - Skip value bypasses CRC check
// - Length and check word LSB first
// - Program from RAM zero, run there
// - CRC over length and program only
// - Reflected CRC-32, all-ones start, inverted
// - Secure boot runs OTP address zero
// - Security word read from OTP first
module plb_top (
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic RST_N,
	input wire logic [1:0] MODE,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic QSPI_CS_N,
	output logic QSPI_SCK,
	output logic [3:0] QSPI_DO,
	output logic [3:0] QSPI_OE,
	input wire logic [3:0] QSPI_DI,
	output logic OTP_RD,
	output logic [10:0] OTP_ADDR,
	input wire logic [31:0] OTP_RDATA,
	output logic RAM_WE,
	output logic [plb_pkg::RAM_AW-1:0] RAM_ADDR,
	output logic [31:0] RAM_WDATA,
	output logic CORE_RUN,
	output logic CORE_FROM_OTP,
	output logic BOOT_ERR,
	output logic GPIO_PD_EN,
	output logic [11:0] PLL_F,
	output logic [5:0] PLL_R,
	output logic [2:0] PLL_OUTPUT_DIVIDER
);
	import plb_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic rst_m_q;
	logic rst_s_q;
	logic [1:0] mode_m_q;
	logic [1:0] mode_s_q;

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
			mode_m_q <= 2'b00;
			mode_s_q <= 2'b00;
		end else begin
			rst_m_q <= RST_N;
			rst_s_q <= rst_m_q;
			mode_m_q <= MODE;
			mode_s_q <= mode_m_q;
		end
	end

	// ==========================================================
	// Declarations
	plb_state_t st_q;
	plb_state_t st_d;
	logic [15:0] dly_q;
	logic sec_step_q;
	logic [31:0] sec_q;
	logic [1:0] strap_q;
	logic [1:0] bcnt_q;
	logic [31:0] word_q;
	logic [31:0] len_q;
	logic [31:0] wcnt_q;
	logic [31:0] chk_q;
	logic skip_q;
	logic cfg_err_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] crc_q;
	plb_qspi_if bs ();

	wire in_hold = ~rst_s_q;
	wire dly_done = (dly_q == 16'(RST_DLY_CYC - 1));
	wire stream = (st_q == S_LEN) | (st_q == S_PROG) | (st_q == S_CHK);
	wire word_done = bs.vld & (bcnt_q == 2'h3);
	wire [31:0] wd = {bs.dat, word_q[31:8]};
	wire crc_ok = (~crc_q == wd);
	wire [31:0] wcnt_n = wcnt_q + 32'h1;

	// ==========================================================
	// Strap table
	logic [11:0] f_boot;

	always_comb begin
		unique case (mode_s_q)
			2'b00: f_boot = F_R40;
			2'b11: f_boot = F_R16;
			2'b10: f_boot = F_R8;
			2'b01: f_boot = F_R4;
		endcase
	end

	// ==========================================================
	// Boot sequencer
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			S_HOLD: st_d = S_DLY;
			S_DLY: st_d = dly_done ? S_SEC : S_DLY;
			S_SEC: st_d = sec_step_q ? S_SEL : S_SEC;
			S_SEL: st_d = sec_q[SEC_BOOT_BIT] ? S_RUN : S_LEN;
			S_LEN: begin
				if (word_done) begin
					if (wd > RAM_WORDS) begin
						st_d = S_ERR;
					end else begin
						st_d = (wd == 32'h0) ? S_CHK : S_PROG;
					end
				end
			end
			S_PROG: st_d = (word_done && wcnt_n == len_q) ? S_CHK : S_PROG;
			S_CHK: begin
				if (word_done) begin
					st_d = (wd == CRC_SKIP || crc_ok) ? S_RUN : S_ERR;
				end
			end
			S_RUN: st_d = S_RUN;
			S_ERR: st_d = S_ERR;
		endcase
		if (in_hold) begin
			st_d = S_HOLD;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			st_q <= S_HOLD;
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			dly_q <= 16'h0000;
			sec_step_q <= 1'b0;
		end else begin
			dly_q <= (st_q == S_DLY) ? dly_q + 16'h0001 : 16'h0000;
			sec_step_q <= (st_q == S_SEC) & ~sec_step_q;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			OTP_RD <= 1'b0;
			OTP_ADDR <= 11'h000;
			sec_q <= 32'h00000000;
		end else begin
			OTP_RD <= (st_q == S_DLY) & dly_done;
			OTP_ADDR <= OTP_SEC_ROW;
			if (st_q == S_SEC && sec_step_q) begin
				sec_q <= OTP_RDATA;
			end
		end
	end

	// ==========================================================
	// Image parser
	// flash stream on while loading
	assign bs.en = stream & ~in_hold;

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			bcnt_q <= 2'h0;
			word_q <= 32'h00000000;
		end else if (!stream) begin
			bcnt_q <= 2'h0;
		end else if (bs.vld) begin
			bcnt_q <= bcnt_q + 2'h1;
			word_q <= wd;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			len_q <= 32'h00000000;
			wcnt_q <= 32'h00000000;
			chk_q <= 32'h00000000;
			skip_q <= 1'b0;
		end else if (word_done) begin
			if (st_q == S_LEN) begin
				len_q <= wd;
				wcnt_q <= 32'h00000000;
			end
			if (st_q == S_PROG) begin
				wcnt_q <= wcnt_n;
			end
			if (st_q == S_CHK) begin
				chk_q <= wd;
				skip_q <= (wd == CRC_SKIP);
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			RAM_WE <= 1'b0;
			RAM_ADDR <= '0;
			RAM_WDATA <= 32'h00000000;
		end else begin
			RAM_WE <= word_done & (st_q == S_PROG);
			RAM_ADDR <= wcnt_q[RAM_AW-1:0];
			RAM_WDATA <= wd;
		end
	end

	plb_crc u_crc (
		.clk(CLK_SYS),
		.rst_n(NRST),
		.init(st_q == S_SEL),
		.upd(bs.vld & ((st_q == S_LEN) | (st_q == S_PROG))),
		.din(bs.dat),
		.crc_q(crc_q)
	);

	plb_qspi u_qspi (
		.clk(CLK_SYS),
		.rst_n(NRST),
		.bs(bs),
		.di(QSPI_DI),
		.cs_n(QSPI_CS_N),
		.sck(QSPI_SCK),
		.dout(QSPI_DO),
		.oe(QSPI_OE)
	);

	// ==========================================================
	// Core start and pins
	// run from address zero
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			CORE_RUN <= 1'b0;
			CORE_FROM_OTP <= 1'b0;
			BOOT_ERR <= 1'b0;
			GPIO_PD_EN <= 1'b1;
		end else begin
			CORE_RUN <= (st_d == S_RUN);
			CORE_FROM_OTP <= (st_d == S_RUN) & sec_q[SEC_BOOT_BIT];
			BOOT_ERR <= (st_d == S_ERR);
			GPIO_PD_EN <= in_hold;
		end
	end

	// ==========================================================
	// AHB-Lite slave
	wire acc = HSEL & HTRANS[1] & HREADY;
	wire [11:0] w_f = HWDATA[PF_F+11:PF_F];
	wire [5:0] w_r = HWDATA[PF_R+5:PF_R];
	wire [2:0] w_out_div = HWDATA[PF_OUT_DIV+2:PF_OUT_DIV];
	wire [31:0] vco_x2 = 32'(OSC_KHZ) * (32'(w_f) + 32'h1);
	wire [31:0] r_p1 = 32'(w_r) + 32'h1;
	wire vco_ok = (vco_x2 >= 32'(2 * VCO_MIN_KHZ) * r_p1) &&
		(vco_x2 <= 32'(2 * VCO_MAX_KHZ) * r_p1);
	wire pll_wr = wr_pend_q & (wr_addr_q == A_PLL);
	wire [31:0] r_pll = {9'h000, PLL_OUTPUT_DIVIDER, 2'b00, PLL_R, PLL_F};
	wire [31:0] r_stat = {17'h00000, strap_q, skip_q, CORE_FROM_OTP,
		cfg_err_q, BOOT_ERR, st_q};
	wire [31:0] rd_mux = (HADDR[7:0] == A_PLL) ? r_pll :
		(HADDR[7:0] == A_STAT) ? r_stat :
		(HADDR[7:0] == A_SEC) ? sec_q :
		(HADDR[7:0] == A_CRC) ? ~crc_q :
		(HADDR[7:0] == A_LEN) ? len_q : 32'h00000000;

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			HRDATA <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			wr_pend_q <= acc & HWRITE & (HADDR[31:8] == 24'h000000);
			wr_addr_q <= HADDR[7:0];
			HRDATA <= (acc && !HWRITE && HADDR[31:8] == 24'h000000) ? rd_mux : 32'h0;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// ==========================================================
	// PLL settings
	// boot dividers on reset release
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			PLL_F <= F_R40;
			PLL_R <= R_BOOT;
			PLL_OUTPUT_DIVIDER <= OUT_DIV_BOOT;
			strap_q <= 2'b00;
			cfg_err_q <= 1'b0;
		end else if (st_q == S_HOLD && !in_hold) begin
			PLL_F <= f_boot;
			PLL_R <= R_BOOT;
			PLL_OUTPUT_DIVIDER <= OUT_DIV_BOOT;
			strap_q <= mode_s_q;
		end else if (pll_wr && vco_ok) begin
			PLL_F <= w_f;
			PLL_R <= w_r;
			PLL_OUTPUT_DIVIDER <= w_out_div;
		end else if (pll_wr) begin
			cfg_err_q <= 1'b1;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);

	sequence s_released;
		(st_q == S_HOLD) ##1 (st_q == S_DLY);
	endsequence

	a_pd_hold: assert property (in_hold |=> GPIO_PD_EN && st_q == S_HOLD)
		else $error("pull-down or hold missing in reset");
	a_dly_length: assert property ($fell(st_q == S_DLY) && st_q == S_SEC
		|-> $past(dly_q) == 16'(RST_DLY_CYC - 1))
		else $error("internal reset delay wrong");
	a_strap_table: assert property (s_released |-> PLL_OUTPUT_DIVIDER == OUT_DIV_BOOT &&
		PLL_R == R_BOOT &&
		PLL_F == ((strap_q == 2'b00) ? F_R40 : (strap_q == 2'b11) ? F_R16 :
		(strap_q == 2'b10) ? F_R8 : F_R4))
		else $error("boot PLL settings do not match strap");
	a_otp_boot: assert property (st_q == S_SEL && sec_q[SEC_BOOT_BIT] |=> CORE_RUN && CORE_FROM_OTP)
		else $error("secure boot did not start from OTP");
	a_flash_boot: assert property (st_q == S_SEL && !sec_q[SEC_BOOT_BIT] |=> st_q == S_LEN ##1 bs.en)
		else $error("flash boot not selected");
	a_crc_skip: assert property (st_q == S_CHK && word_done && wd == CRC_SKIP |=> CORE_RUN)
		else $error("skip value did not bypass check");
	a_crc_fail: assert property (st_q == S_CHK && word_done && wd != CRC_SKIP && !crc_ok
		|=> (BOOT_ERR && !CORE_RUN) [*2])
		else $error("bad CRC did not stop boot");
	a_ram_first: assert property ($rose(st_q == S_PROG) |-> wcnt_q == 32'h0)
		else $error("program not loaded from RAM zero");
	a_pll_write: assert property (pll_wr && vco_ok && st_q != S_HOLD |=> PLL_F == $past(w_f)
		&& PLL_OUTPUT_DIVIDER == $past(w_out_div))
		else $error("PLL write not applied");
endmodule // plb_top

/* testbench/plb_flash_model.sv */
// Behavioural quad-output boot flash on the far side of the reader
module plb_flash_model (
	input wire logic cs_n,
	input wire logic sck,
	input wire logic [3:0] dq_in,
	output logic [3:0] dq_out,
	output logic [31:0] hdr_q
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:63];
	int cnt = 0;
	logic [7:0] b;
	initial dq_out = 4'hA;
	always @(negedge cs_n) begin
		cnt = 0;
		hdr_q = 32'h0;
	end
	always @(posedge sck) if (!cs_n && cnt < 32) hdr_q = {hdr_q[30:0], dq_in[0]};
	// bytes out high nibble first after 8 dummy clocks
	always @(negedge sck) if (!cs_n) begin
		cnt = cnt + 1;
		b = mem[((cnt - 40) >> 1) & 63];
		if (cnt >= 40) dq_out = cnt[0] ? b[3:0] : b[7:4];
	end
	// Released lines show no stale data
	always @(posedge cs_n) dq_out = ~dq_out;
endmodule // plb_flash_model

/* testbench/pll_strap_and_boot_loader_bench.sv */
// Self-checking bench of the strap, reset and boot loader block
`define CHK(a, b) begin \
	checks++; \
	if ((a) !== (b)) begin \
		err_count++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); \
	end \
end
module pll_strap_and_boot_loader_bench;
	import plb_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK_SYS, NRST, RST_N, HSEL, HWRITE;
	logic [1:0] MODE, HTRANS;
	logic [2:0] HSIZE;
	logic [31:0] HADDR, HWDATA, HRDATA, RAM_WDATA;
	logic [31:0] OTP_RDATA = 32'h0;
	logic HREADY, HREADYOUT, HRESP, QSPI_CS_N, QSPI_SCK, OTP_RD, RAM_WE;
	logic CORE_RUN, CORE_FROM_OTP, BOOT_ERR, GPIO_PD_EN;
	logic [3:0] QSPI_DO, QSPI_OE, QSPI_DI, fl_dq;
	logic [10:0] OTP_ADDR, otp_seen;
	logic [RAM_AW-1:0] RAM_ADDR;
	logic [11:0] PLL_F;
	logic [5:0] PLL_R;
	logic [2:0] PLL_OUTPUT_DIVIDER;
	logic [31:0] hdr, sec_word, exp_crc, rd;
	logic [46:0] ram_q [$];
	logic cs_seen;
	int err_count = 0;
	int checks = 0;
	assign HREADY = HREADYOUT;
	assign QSPI_DI = (QSPI_OE & QSPI_DO) | (~QSPI_OE & fl_dq);
	initial begin
		CLK_SYS = 1'b0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end
	always @(posedge CLK_SYS) begin
		OTP_RDATA <= OTP_RD ? ((OTP_ADDR == OTP_SEC_ROW) ? sec_word : 32'h0) : ~OTP_RDATA;
		if (OTP_RD === 1'b1) otp_seen <= OTP_ADDR;
		if (RAM_WE === 1'b1) ram_q.push_back({RAM_ADDR, RAM_WDATA});
		if (QSPI_CS_N === 1'b0) cs_seen <= 1'b1;
	end
	plb_top i_plb_top (.CLK_SYS(CLK_SYS), .NRST(NRST), .RST_N(RST_N), .MODE(MODE),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
		.HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .QSPI_CS_N(QSPI_CS_N), .QSPI_SCK(QSPI_SCK), .QSPI_DO(QSPI_DO),
		.QSPI_OE(QSPI_OE), .QSPI_DI(QSPI_DI), .OTP_RD(OTP_RD), .OTP_ADDR(OTP_ADDR),
		.OTP_RDATA(OTP_RDATA), .RAM_WE(RAM_WE), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA),
		.CORE_RUN(CORE_RUN), .CORE_FROM_OTP(CORE_FROM_OTP), .BOOT_ERR(BOOT_ERR),
		.GPIO_PD_EN(GPIO_PD_EN), .PLL_F(PLL_F), .PLL_R(PLL_R),
		.PLL_OUTPUT_DIVIDER(PLL_OUTPUT_DIVIDER));
	plb_flash_model i_plb_flash_model (.cs_n(QSPI_CS_N), .sck(QSPI_SCK), .dq_in(QSPI_DI),
		.dq_out(fl_dq), .hdr_q(hdr));
	// ==========================================================
	// Helpers
	task automatic results();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tmo();
		err_count++;
		results();
	endtask
	function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] b);
		c = c ^ {24'h0, b};
		for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
		return c;
	endfunction
	function automatic logic [31:0] pword(input int i);
		return 32'hA5C30011 + i * 32'h01020304;
	endfunction
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rdat);
		int n;
		n = 0;
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= wr;
		HSIZE <= 3'h2;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (HREADY !== 1'b1 && n < 16);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (HREADY !== 1'b1 && n < 16);
		rdat = HRDATA;
		if (n >= 16) tmo();
	endtask
	// Image: length, n words, check word (mode 0 good, 1 skip, 2 bad)
	task automatic load_img(input int n, input int mode);
		logic [31:0] c;
		logic [31:0] w;
		c = 32'hFFFFFFFF;
		for (int i = 0; i <= n; i++) begin
			w = (i == 0) ? n : pword(i - 1);
			for (int b = 0; b < 4; b++) begin
				i_plb_flash_model.mem[4 * i + b] = w[8 * b +: 8];
				c = crc_upd(c, w[8 * b +: 8]);
			end
		end
		exp_crc = ~c;
		w = (mode == 1) ? 32'h0D15AB1E : (exp_crc ^ {31'h0, mode == 2});
		for (int b = 0; b < 4; b++) i_plb_flash_model.mem[4 * (n + 1) + b] = w[8 * b +: 8];
	endtask
	task automatic boot(input logic [1:0] md);
		int n;
		int dly;
		MODE <= md;
		RST_N <= 1'b0;
		repeat (8) @(posedge CLK_SYS);
		`CHK(GPIO_PD_EN, 1'b1)
		ram_q.delete();
		cs_seen = 1'b0;
		RST_N <= 1'b1;
		dly = 0;
		for (n = 0; n < 20000 && !(CORE_RUN | BOOT_ERR); n++) begin
			@(posedge CLK_SYS);
			if (QSPI_CS_N && !cs_seen) dly++;
		end
		if (n == 20000) tmo();
		repeat (2) @(posedge CLK_SYS);
		`CHK(GPIO_PD_EN, 1'b0)
		if (sec_word == 32'h0) `CHK(dly >= 1500 && dly <= 15000, 1'b1)
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset_vals();
		`CHK({PLL_OUTPUT_DIVIDER, PLL_R, PLL_F}, {3'h1, 6'h00, 12'h09F})
		`CHK({QSPI_CS_N, HRESP, GPIO_PD_EN}, 3'h5)
	endtask
	task automatic t_straps();
		logic [1:0] md_t [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
		logic [11:0] f_t [4] = '{12'h09F, 12'h03F, 12'h01F, 12'h00F};
		for (int i = 0; i < 4; i++) begin
			load_img(0, 1);
			boot(md_t[i]);
			`CHK(PLL_F, f_t[i])
			`CHK({PLL_OUTPUT_DIVIDER, PLL_R}, {3'h1, 6'h00})
			`CHK({CORE_RUN, BOOT_ERR}, 2'h2)
		end
	endtask
	task automatic t_crc_ok();
		load_img(4, 0);
		boot(2'h3);
		`CHK(hdr, 32'h6B000000)
		`CHK(cs_seen, 1'b1)
		`CHK(ram_q.size(), 4)
		for (int i = 0; i < 4 && i < ram_q.size(); i++) `CHK(ram_q[i], {i[14:0], pword(i)})
		`CHK({CORE_RUN, CORE_FROM_OTP, BOOT_ERR}, 3'h4)
		ahb(1'b0, {24'h0, A_CRC}, 32'h0, rd);
		`CHK(rd, exp_crc)
		ahb(1'b0, {24'h0, A_LEN}, 32'h0, rd);
		`CHK(rd, 32'h4)
	endtask
	task automatic t_crc_bad();
		load_img(3, 2);
		boot(2'h3);
		`CHK({CORE_RUN, BOOT_ERR}, 2'h1)
		ahb(1'b0, {24'h0, A_CRC}, 32'h0, rd);
		`CHK(rd, exp_crc)
	endtask
	task automatic t_secure();
		sec_word = 32'h00000020;
		load_img(2, 0);
		boot(2'h3);
		`CHK({CORE_RUN, CORE_FROM_OTP, cs_seen}, 3'h6)
		`CHK(otp_seen, OTP_SEC_ROW)
		ahb(1'b0, {24'h0, A_SEC}, 32'h0, rd);
		`CHK(rd, 32'h00000020)
		sec_word = 32'h0;
	endtask
	task automatic t_pll();
		ahb(1'b1, {24'h0, A_PLL}, 32'h0010004F, rd);
		@(posedge CLK_SYS);
		`CHK({PLL_OUTPUT_DIVIDER, PLL_R, PLL_F}, {3'h1, 6'h00, 12'h04F})
		`CHK(25000 * (PLL_F + 1) / 2 / (PLL_R + 1) / (PLL_OUTPUT_DIVIDER + 1), 500000)
		ahb(1'b1, {24'h0, A_PLL}, 32'h00100FFF, rd);
		ahb(1'b0, {24'h0, A_PLL}, 32'h0, rd);
		`CHK(rd, 32'h0010004F)
		ahb(1'b0, {24'h0, A_STAT}, 32'h0, rd);
		`CHK(rd[10], 1'b1)
		ahb(1'b0, 32'h00000040, 32'h0, rd);
		`CHK(rd, 32'h0)
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		NRST = 1'b0;
		RST_N = 1'b0;
		MODE = 2'h0;
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h0;
		sec_word = 32'h0;
		cs_seen = 1'b0;
		repeat (16) @(posedge CLK_SYS);
		NRST <= 1'b1;
		@(posedge CLK_SYS);
		t_reset_vals();
		t_straps();
		t_crc_ok();
		t_crc_bad();
		t_secure();
		t_pll();
		results();
	end
endmodule // pll_strap_and_boot_loader_bench
